// >>> logic/host_channel3_status_reg.sv
`timescale 1ns/1ps
`default_nettype none
module host_channel3_status_reg (
  input  wire logic                                 clock,               // System clock, 10 MHz.
  input  wire logic                                 reset,               // Synchronous reset, high.
  input  wire logic                                 host_write_input,    // Host input data write.
  input  wire logic [host_ch3_pkg::HOST_ADDR_W-1:0] host_io_addr,        // Host I/O address.
  input  wire logic                                 host_read_output,    // Host output data read.
  input  wire logic                                 host_write_last_twr, // Host last two-way write.
  input  wire logic                                 slave_read_input,    // Slave input data read.
  input  wire logic                                 slave_write_output,  // Slave output data write.
  input  wire logic                                 slave_read_last_twr, // Slave last two-way read.
  input  wire logic                                 slave_status_write,  // Slave status write.
  input  wire logic [host_ch3_pkg::STATUS_W-1:0]    slave_status_wdata,  // Slave status write data.
  input  wire logic                                 two_way_register_enable, // Two-way mode on.
  input  wire logic                                 status_layout_select,    // User layout select.
  output logic      [host_ch3_pkg::STATUS_W-1:0]    status_q,            // Status as read by both.
  output logic                                      input_irq_q,         // Input-full request.
  output logic                                      bidir_irq_q,         // Bidir input-full request.
  output logic                                      user_layout_q        // User layout in force.
);

  // Flag state and its next values.
  logic                                 command_data_flag_q;
  logic                                 command_data_flag_d;
  logic                                 input_full_flag_q;
  logic                                 input_full_flag_d;
  logic                                 output_full_flag_q;
  logic                                 output_full_flag_d;
  logic                                 bidir_input_full_flag_q;
  logic                                 bidir_input_full_flag_d;
  logic                                 user_bit_2_q;
  logic                                 user_bit_2_d;
  logic [host_ch3_pkg::USER_HI_W-1:0]   user_hi_q;
  logic [host_ch3_pkg::USER_HI_W-1:0]   user_hi_d;
  logic                                 user_layout;

  // Builds the status byte for the layout in force.
  function automatic logic [host_ch3_pkg::STATUS_W-1:0] compose(
    input logic                               user_lay,
    input logic                               bidir_ibf,
    input logic [host_ch3_pkg::USER_HI_W-1:0] hi,
    input logic                               cmd,
    input logic                               usr2,
    input logic                               ibf,
    input logic                               obf
  );
    logic [host_ch3_pkg::STATUS_W-1:0] v;
    v = host_ch3_pkg::STATUS_RESET;
    if (user_lay) begin
      v[host_ch3_pkg::USER_HI_LSB +: host_ch3_pkg::USER_HI_W] = hi;
    end else begin
      v[host_ch3_pkg::BIDIR_IBF_BIT] = bidir_ibf;
    end
    v[host_ch3_pkg::CMD_BIT]   = cmd;
    v[host_ch3_pkg::USER2_BIT] = usr2;
    v[host_ch3_pkg::IBF_BIT]   = ibf;
    v[host_ch3_pkg::OBF_BIT]   = obf;
    return v;
  endfunction

  // The user layout holds only while the two-way registers are off.
  assign user_layout = !two_way_register_enable && status_layout_select;

  // Command/data follows the host address on every input write and is never
  // written by the slave, so the status write path leaves it alone.
  always_comb begin
    command_data_flag_d = command_data_flag_q;
    if (host_write_input) begin
      command_data_flag_d = host_io_addr[host_ch3_pkg::CMD_ADDR_BIT];
    end
  end

  // Input-full: the host write wins over a slave read in the same cycle, so
  // a byte arriving just as the previous one is taken is never lost.
  always_comb begin
    input_full_flag_d = input_full_flag_q;
    if (slave_read_input) begin
      input_full_flag_d = 1'b0;
    end
    if (host_write_input) begin
      input_full_flag_d = 1'b1;
    end
  end

  // Output-full: host read and slave zero-write clear it, a slave data write
  // sets it and takes priority over both clears.
  always_comb begin
    output_full_flag_d = output_full_flag_q;
    if (host_read_output) begin
      output_full_flag_d = 1'b0;
    end
    if (slave_status_write && !slave_status_wdata[host_ch3_pkg::OBF_BIT]) begin
      output_full_flag_d = 1'b0;
    end
    if (slave_write_output) begin
      output_full_flag_d = 1'b1;
    end
  end

  // Bidirectional input-full tracks the last two-way data register, with the
  // host write winning over a slave read in the same cycle.
  always_comb begin
    bidir_input_full_flag_d = bidir_input_full_flag_q;
    if (slave_read_last_twr) begin
      bidir_input_full_flag_d = 1'b0;
    end
    if (host_write_last_twr) begin
      bidir_input_full_flag_d = 1'b1;
    end
  end

  // User bits take slave writes only; the upper four exist in the status
  // byte only in the user layout, so writes there are dropped otherwise.
  always_comb begin
    user_bit_2_d = user_bit_2_q;
    user_hi_d    = user_hi_q;
    if (slave_status_write) begin
      user_bit_2_d = slave_status_wdata[host_ch3_pkg::USER2_BIT];
      if (user_layout) begin
        user_hi_d = slave_status_wdata[host_ch3_pkg::USER_HI_LSB +: host_ch3_pkg::USER_HI_W];
      end
    end
  end

  // Flag registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      command_data_flag_q     <= host_ch3_pkg::FLAG_RESET;
      input_full_flag_q       <= host_ch3_pkg::FLAG_RESET;
      output_full_flag_q      <= host_ch3_pkg::FLAG_RESET;
      bidir_input_full_flag_q <= host_ch3_pkg::FLAG_RESET;
    end else begin
      command_data_flag_q     <= command_data_flag_d;
      input_full_flag_q       <= input_full_flag_d;
      output_full_flag_q      <= output_full_flag_d;
      bidir_input_full_flag_q <= bidir_input_full_flag_d;
    end
  end

  // User bit registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      user_bit_2_q <= host_ch3_pkg::FLAG_RESET;
      user_hi_q    <= host_ch3_pkg::USER_HI_RESET;
    end else begin
      user_bit_2_q <= user_bit_2_d;
      user_hi_q    <= user_hi_d;
    end
  end

  // The visible byte is built from the next values, so it always agrees with
  // the flags themselves; a layout change shows on the next edge, together with user_layout_q.
  always_ff @(posedge clock) begin
    if (reset) begin
      status_q      <= host_ch3_pkg::STATUS_RESET;
      user_layout_q <= host_ch3_pkg::FLAG_RESET;
    end else begin
      status_q      <= compose(user_layout, bidir_input_full_flag_d, user_hi_d,
                               command_data_flag_d, user_bit_2_d,
                               input_full_flag_d, output_full_flag_d);
      user_layout_q <= user_layout;
    end
  end

  // Interrupt requests to the slave follow the input-full flags.
  always_ff @(posedge clock) begin
    if (reset) begin
      input_irq_q <= host_ch3_pkg::FLAG_RESET;
      bidir_irq_q <= host_ch3_pkg::FLAG_RESET;
    end else begin
      input_irq_q <= input_full_flag_d;
      bidir_irq_q <= bidir_input_full_flag_d;
    end
  end

  // Command/data reflects the address of the most recent host input write.
  a_cmd_follows_addr: assert property (@(posedge clock) disable iff (reset)
    host_write_input |=> status_q[host_ch3_pkg::CMD_BIT] ==
      $past(host_io_addr[host_ch3_pkg::CMD_ADDR_BIT]))
    else $error("Command/data flag does not match host address.");

  // A host input write always leaves input-full set.
  a_ibf_set: assert property (@(posedge clock) disable iff (reset)
    host_write_input |=> status_q[host_ch3_pkg::IBF_BIT] && input_irq_q)
    else $error("Input-full not set after host write.");

  // A slave read alone clears input-full.
  a_ibf_clear: assert property (@(posedge clock) disable iff (reset)
    slave_read_input && !host_write_input |=> !status_q[host_ch3_pkg::IBF_BIT])
    else $error("Input-full not cleared by slave read.");

  // The interrupt request equals the visible input-full bit.
  a_irq_tracks_ibf: assert property (@(posedge clock) disable iff (reset)
    input_irq_q == status_q[host_ch3_pkg::IBF_BIT])
    else $error("Input interrupt differs from input-full.");

  // A slave output write sets output-full even against a host read.
  a_obf_set_wins: assert property (@(posedge clock) disable iff (reset)
    slave_write_output |=> status_q[host_ch3_pkg::OBF_BIT])
    else $error("Output-full not set after slave write.");

  // A host read clears output-full when the slave does not write.
  a_obf_host_clear: assert property (@(posedge clock) disable iff (reset)
    host_read_output && !slave_write_output |=> !status_q[host_ch3_pkg::OBF_BIT])
    else $error("Output-full not cleared by host read.");

  // A slave status write can never raise output-full.
  a_obf_no_set: assert property (@(posedge clock) disable iff (reset)
    !status_q[host_ch3_pkg::OBF_BIT] && !slave_write_output
    |=> !status_q[host_ch3_pkg::OBF_BIT])
    else $error("Output-full rose without an output write.");

  // Input-full cannot rise without a host write.
  a_ibf_no_set: assert property (@(posedge clock) disable iff (reset)
    !status_q[host_ch3_pkg::IBF_BIT] && !host_write_input
    |=> !status_q[host_ch3_pkg::IBF_BIT])
    else $error("Input-full rose without a host write.");

  // User bit 2 holds the value last written by the slave.
  a_user2_write: assert property (@(posedge clock) disable iff (reset)
    slave_status_write |=> status_q[host_ch3_pkg::USER2_BIT] ==
      $past(slave_status_wdata[host_ch3_pkg::USER2_BIT]))
    else $error("User bit 2 lost a slave write.");

  // In the user layout the upper nibble shows the stored user bits.
  a_user_layout_hi: assert property (@(posedge clock) disable iff (reset)
    user_layout |=>
      status_q[host_ch3_pkg::USER_HI_LSB +: host_ch3_pkg::USER_HI_W] == user_hi_q)
    else $error("Upper user bits not shown in user layout.");

  // In the two-way layout bit 7 is bidir input-full and bits 6 to 4 are zero.
  a_two_way_layout: assert property (@(posedge clock) disable iff (reset)
    !user_layout |=> status_q[host_ch3_pkg::BIDIR_IBF_BIT] == bidir_irq_q &&
      status_q[host_ch3_pkg::BIDIR_IBF_BIT-1:host_ch3_pkg::USER_HI_LSB] == '0)
    else $error("Two-way layout bits wrong.");

  // A host last two-way write sets, a lone slave read clears bidir input-full.
  a_bidir_flag: assert property (@(posedge clock) disable iff (reset)
    (host_write_last_twr |=> bidir_irq_q) and
    (slave_read_last_twr && !host_write_last_twr |=> !bidir_irq_q))
    else $error("Bidirectional input-full wrong.");

  // Command/data changes only on a host input write; the slave cannot touch it.
  a_cmd_read_only: assert property (@(posedge clock) disable iff (reset)
    !host_write_input |=> $stable(status_q[host_ch3_pkg::CMD_BIT]))
    else $error("Command/data changed without a host write.");

  // A slave zero write clears output-full unless an output write lands with it.
  a_obf_zero_clear: assert property (@(posedge clock) disable iff (reset)
    slave_status_write && !slave_status_wdata[host_ch3_pkg::OBF_BIT] && !slave_write_output
    |=> !status_q[host_ch3_pkg::OBF_BIT])
    else $error("Output-full not cleared by a slave zero write.");

  // Once set, output-full stays set until a host read or a slave zero write.
  a_obf_hold: assert property (@(posedge clock) disable iff (reset)
    status_q[host_ch3_pkg::OBF_BIT] && !host_read_output &&
    !(slave_status_write && !slave_status_wdata[host_ch3_pkg::OBF_BIT])
    |=> status_q[host_ch3_pkg::OBF_BIT])
    else $error("Output-full dropped without a clearing event.");

  // Once set, input-full stays set until the slave reads the input data.
  a_ibf_hold: assert property (@(posedge clock) disable iff (reset)
    status_q[host_ch3_pkg::IBF_BIT] && !slave_read_input |=> status_q[host_ch3_pkg::IBF_BIT])
    else $error("Input-full dropped without a slave read.");

  // A host write that meets a slave read still leaves input-full set.
  a_ibf_set_wins: assert property (@(posedge clock) disable iff (reset)
    host_write_input && slave_read_input |=> status_q[host_ch3_pkg::IBF_BIT])
    else $error("Input-full lost a host write against a slave read.");

  // User bit 2 changes only on a slave status write.
  a_user2_hold: assert property (@(posedge clock) disable iff (reset)
    !slave_status_write |=> $stable(status_q[host_ch3_pkg::USER2_BIT]))
    else $error("User bit 2 changed without a slave write.");

  // The stored upper user bits change only on a slave status write.
  a_user_hi_hold: assert property (@(posedge clock) disable iff (reset)
    !slave_status_write |=> $stable(user_hi_q))
    else $error("Upper user bits changed without a slave write.");

  // The upper user bits take a slave write while the user layout holds.
  a_user_hi_write: assert property (@(posedge clock) disable iff (reset)
    slave_status_write && user_layout
    |=> user_hi_q ==
      $past(slave_status_wdata[host_ch3_pkg::USER_HI_LSB +: host_ch3_pkg::USER_HI_W]))
    else $error("Upper user bits lost a slave write.");

  // Reset clears every output on the next edge, user bits included.
  a_reset_clears: assert property (@(posedge clock)
    reset |=> status_q == host_ch3_pkg::STATUS_RESET && !input_irq_q && !bidir_irq_q &&
      !user_layout_q)
    else $error("Outputs not cleared by reset.");

  // The layout flag follows the configuration pins one edge late.
  a_layout_flag: assert property (@(posedge clock) disable iff (reset)
    !reset |=> user_layout_q == $past(user_layout))
    else $error("Layout flag does not follow the configuration.");

  // Bidirectional input-full changes only on its own host write or slave read.
  a_bidir_hold: assert property (@(posedge clock) disable iff (reset)
    !host_write_last_twr && !slave_read_last_twr |=> $stable(bidir_irq_q))
    else $error("Bidirectional input-full changed without an event.");

endmodule : host_channel3_status_reg
`default_nettype wire

// >>> logic/host_ch3_pkg.sv
`default_nettype none
package host_ch3_pkg;

  // Width of the status register as both processors see it.
  localparam int unsigned STATUS_W = 8;

  // Width of the host I/O address that accompanies a host write.
  localparam int unsigned HOST_ADDR_W = 16;

  // Host address bit that tells a command from data on an input write.
  localparam int unsigned CMD_ADDR_BIT = 2;

  // Bit positions common to both layouts.
  localparam int unsigned CMD_BIT   = 3;
  localparam int unsigned USER2_BIT = 2;
  localparam int unsigned IBF_BIT   = 1;
  localparam int unsigned OBF_BIT   = 0;

  // Bit positions that depend on the layout.
  localparam int unsigned BIDIR_IBF_BIT = 7;
  localparam int unsigned USER_HI_LSB   = 4;
  localparam int unsigned USER_HI_W     = 4;

  // Reset values.
  localparam logic [STATUS_W-1:0]  STATUS_RESET  = 8'h00;
  localparam logic [USER_HI_W-1:0] USER_HI_RESET = 4'h0;
  localparam logic                 FLAG_RESET    = 1'b0;

endpackage : host_ch3_pkg
`default_nettype wire

// >>> test/host_ch3_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ch3_host_model (
  input  wire logic                                 clock,               // System clock.
  output logic                                      host_write_input,    // Input data write.
  output logic      [host_ch3_pkg::HOST_ADDR_W-1:0] host_io_addr,        // I/O address.
  output logic                                      host_read_output,    // Output data read.
  output logic                                      host_write_last_twr  // Last two-way write.
);
  // Idle host: no strobes, address bus parked at an arbitrary pattern.
  initial begin
    host_write_input    = 1'b0;
    host_read_output    = 1'b0;
    host_write_last_twr = 1'b0;
    host_io_addr        = 16'h0060;
  end

  // One host I/O cycle: 0 input write, 1 output read, 2 last two-way write.
  // The host only writes data registers, never the status byte.
  task automatic io_cycle(input int kind, input logic cmd);
    @(posedge clock);
    host_write_input    <= (kind == 0);
    host_read_output    <= (kind == 1);
    host_write_last_twr <= (kind == 2);
    host_io_addr        <= 16'h0060 | {13'h0000, cmd, 2'h0};
    @(posedge clock);
    host_write_input    <= 1'b0;
    host_read_output    <= 1'b0;
    host_write_last_twr <= 1'b0;
    // A released bus no longer holds the old address, so show its inverse.
    host_io_addr        <= ~host_io_addr;
  endtask
endmodule // host_ch3_host_model
`default_nettype wire

// >>> test/host_channel3_status_reg_test.sv
`timescale 1ns/1ps
`default_nettype none
module host_channel3_status_reg_test;
  logic                                      clock;
  logic                                      reset;
  logic                                      host_write_input;
  logic [host_ch3_pkg::HOST_ADDR_W-1:0]      host_io_addr;
  logic                                      host_read_output;
  logic                                      host_write_last_twr;
  logic                                      slave_read_input;
  logic                                      slave_write_output;
  logic                                      slave_read_last_twr;
  logic                                      slave_status_write;
  logic [host_ch3_pkg::STATUS_W-1:0]         slave_status_wdata;
  logic                                      two_way_register_enable;
  logic                                      status_layout_select;
  logic [host_ch3_pkg::STATUS_W-1:0]         status_q;
  logic                                      input_irq_q;
  logic                                      bidir_irq_q;
  logic                                      user_layout_q;
  int                                        n_mismatch;
  int                                        tests_run;

  host_channel3_status_reg u_host_channel3_status_reg (
    .clock(clock), .reset(reset), .host_write_input(host_write_input),
    .host_io_addr(host_io_addr), .host_read_output(host_read_output),
    .host_write_last_twr(host_write_last_twr), .slave_read_input(slave_read_input),
    .slave_write_output(slave_write_output), .slave_read_last_twr(slave_read_last_twr),
    .slave_status_write(slave_status_write), .slave_status_wdata(slave_status_wdata),
    .two_way_register_enable(two_way_register_enable),
    .status_layout_select(status_layout_select), .status_q(status_q),
    .input_irq_q(input_irq_q), .bidir_irq_q(bidir_irq_q), .user_layout_q(user_layout_q));

  host_ch3_host_model u_host_ch3_host_model (
    .clock(clock), .host_write_input(host_write_input), .host_io_addr(host_io_addr),
    .host_read_output(host_read_output), .host_write_last_twr(host_write_last_twr));

  // Free-running 10 MHz clock.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Slave strobe: 0 input read, 1 output write, 2 last two-way read, 3 status write.
  task automatic slave_op(input int kind, input logic [7:0] wdata);
    @(posedge clock);
    slave_read_input    <= (kind == 0);
    slave_write_output  <= (kind == 1);
    slave_read_last_twr <= (kind == 2);
    slave_status_write  <= (kind == 3);
    slave_status_wdata  <= wdata;
    @(posedge clock);
    {slave_read_input, slave_write_output, slave_read_last_twr, slave_status_write} <= 4'h0;
    // Stale write data is inverted so a late sample cannot look right.
    slave_status_wdata  <= ~wdata;
  endtask

  // The result lands on the edge that ends an operation; look just after it.
  task automatic check_status(input logic [7:0] exp);
    #1;
    tests_run++;
    if (status_q !== exp) begin
      n_mismatch++;
      $display("unexpected status at %0t: got %h want %h", $time, status_q, exp);
    end
  endtask

  // The flag value is taken when the task is called, not after its #1; every call follows check_status, so it is off the edge too.
  task automatic check_flag(input logic got, input logic exp);
    #1;
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Changing the layout needs one edge to land and one to show.
  task automatic set_layout(input logic two_way, input logic sel);
    @(posedge clock);
    two_way_register_enable <= two_way;
    status_layout_select    <= sel;
    repeat (2) @(posedge clock);
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    reset = 1'b1;
    {slave_read_input, slave_write_output, slave_read_last_twr, slave_status_write} = 4'h0;
    slave_status_wdata = 8'h00;
    two_way_register_enable = 1'b0;
    status_layout_select = 1'b0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    check_status(8'h00);
    check_flag(user_layout_q, 1'b0);
    u_host_ch3_host_model.io_cycle(0, 1'b1);
    check_status(8'h0a);
    check_flag(input_irq_q, 1'b1);
    slave_op(0, 8'h00);
    check_status(8'h08);
    check_flag(input_irq_q, 1'b0);
    u_host_ch3_host_model.io_cycle(0, 1'b0);
    check_status(8'h02);
    slave_op(0, 8'h00);
    slave_op(1, 8'h00);
    check_status(8'h01);
    // Read-only flags and hidden upper bits must ignore the slave write.
    slave_op(3, 8'hff);
    check_status(8'h05);
    slave_op(3, 8'h04);
    check_status(8'h04);
    slave_op(1, 8'h00);
    u_host_ch3_host_model.io_cycle(1, 1'b0);
    check_status(8'h04);
    fork
      u_host_ch3_host_model.io_cycle(1, 1'b0);
      slave_op(1, 8'h00);
    join
    check_status(8'h05);
    // Host input write against a slave read, then host read against a slave output write.
    fork
      u_host_ch3_host_model.io_cycle(0, 1'b0);
      slave_op(0, 8'h00);
    join
    check_status(8'h07);
    slave_op(0, 8'h00);
    check_status(8'h05);
    fork
      u_host_ch3_host_model.io_cycle(1, 1'b0);
      slave_op(1, 8'h00);
    join
    check_status(8'h05);
    set_layout(1'b0, 1'b1);
    check_status(8'h05);
    check_flag(user_layout_q, 1'b1);
    slave_op(3, 8'ha5);
    check_status(8'ha5);
    slave_op(3, 8'h50);
    check_status(8'h50);
    set_layout(1'b1, 1'b1);
    check_status(8'h00);
    check_flag(user_layout_q, 1'b0);
    u_host_ch3_host_model.io_cycle(2, 1'b0);
    check_status(8'h80);
    check_flag(bidir_irq_q, 1'b1);
    slave_op(2, 8'h00);
    check_status(8'h00);
    // Mid-run reset: upper user bits stored earlier must come back as zero.
    slave_op(3, 8'h04);
    check_status(8'h04);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    check_status(8'h00);
    set_layout(1'b0, 1'b1);
    check_status(8'h00);
    check_flag(user_layout_q, 1'b1);
    give_verdict();
  end
endmodule // host_channel3_status_reg_test
`default_nettype wire
